// ---- shared/tone_bus_lock_pkg.sv ----
// Package with register map, field positions and carriers of the block.
package tone_bus_lock_pkg;

    // ******************************************************************
    // Register offsets
    // ******************************************************************
    localparam logic [7:0] CONVERTER_VALUE_LOW_OFS = 8'h07;
    localparam logic [7:0] TONE_BUS_LOCK_CONTROL_OFS = 8'h08;
    localparam logic [7:0] TONE_BUS_FIFO_DATA_OFS = 8'h09;
    localparam logic [7:0] TONE_BUS_STATUS_OFS = 8'h0a;
    localparam logic [7:0] RESERVED_SLOT_OFS = 8'h0b;

    // ******************************************************************
    // Reset values
    // ******************************************************************
    localparam logic [7:0] CONVERTER_VALUE_LOW_RST = 8'h00;
    localparam logic [7:0] TONE_BUS_LOCK_CONTROL_RST = 8'h60;
    localparam logic [7:0] TONE_BUS_FIFO_DATA_RST = 8'h00;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int LOCK_SEL_MSB = 7;
    localparam int LOCK_SEL_LSB = 6;
    localparam int LOCK_OPEN_DRAIN_BIT = 5;
    localparam int BURST_SEL_BIT = 2;
    localparam int STATUS_INPUT_PIN_BIT = 7;
    localparam int STATUS_REPEATER_BIT = 6;
    localparam int STATUS_EMPTY_BIT = 1;
    localparam int STATUS_FULL_BIT = 0;

    // ******************************************************************
    // Sizes
    // ******************************************************************
    localparam int CONVERTER_WIDTH = 12;
    localparam int FIFO_DEPTH_DEFAULT = 8;

    // ******************************************************************
    // Lock pin selector codes
    // ******************************************************************
    localparam logic [1:0] LOCK_SEL_LOW = 2'h0;
    localparam logic [1:0] LOCK_SEL_HIGH = 2'h1;
    localparam logic [1:0] LOCK_SEL_CARRIER = 2'h2;
    localparam logic [1:0] LOCK_SEL_LOCKED = 2'h3;

    // ******************************************************************
    // Carriers
    // ******************************************************************
    typedef struct packed {
        logic [1:0] lockSel;
        logic lockOpenDrain;
        logic [1:0] spare;
        logic burstSel;
        logic [1:0] toneMode;
    } tone_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic read;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// ---- logic/tone_bus_lock_status_regs.sv ----
// Register slice for converter low byte, lock pin, tone bus FIFO and status.
//
// Operation
// R1: The lock pin follows a two-bit selector: low, high, carrier, locked.
// R2: Control bit 5 makes the lock pin open drain when 1 and push-pull when 0.
// R3: Software writes zeros to control bits 4 and 3.
// R4: Status bit 7 returns the level on the general input pin.
// R5: Status bit 6 returns the state of the repeater data line.
// R6: Status bit 1 flags the transmit FIFO empty and bit 0 flags it full.
// R7: Offset 09 queues each byte written while the FIFO is not full for the tone bus and resets to 0.
// R8: Offset 07 holds the low eight converter bits and resets to zero.
// R9: Control bit 2 chooses modulated messaging or a plain tone burst.
// R10: The converter value is the high nibble above the offset 07 byte.
// R11: A FIFO write while full is ignored and leaves the FIFO unchanged.
`timescale 1ns/1ps

module tone_bus_lock_status_regs
    import tone_bus_lock_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire reg_req_t regReq,
    output logic [7:0] regRData,
    input wire logic [3:0] converterHighNibble,
    output logic [CONVERTER_WIDTH-1:0] converterValue,
    input wire logic carrierFound,
    input wire logic demodLocked,
    output logic lockPinOut,
    output logic lockPinOe,
    input wire logic generalInputPin,
    input wire logic repeaterDataLine,
    output logic burstSel,
    output logic [1:0] toneMode,
    output logic txValid,
    output logic [7:0] txData,
    input wire logic txReady
);

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(FIFO_DEPTH);
    localparam logic [PW-1:0] LAST_IDX = PW'(FIFO_DEPTH - 1);

    // ******************************************************************
    // Register state
    // ******************************************************************
    logic [7:0] convLow_reg, convLow_next;
    tone_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] fifoData_reg, fifoData_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [CONVERTER_WIDTH-1:0] conv_reg, conv_next;
    logic lockOut_reg, lockOut_next;
    logic lockOe_reg, lockOe_next;
    logic lockLevel;
    logic [7:0] status;

    // ******************************************************************
    // Transmit FIFO state
    // ******************************************************************
    logic [7:0] mem_reg [FIFO_DEPTH];
    logic [PW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [PW:0] count_reg, count_next;
    logic fifoFull, fifoEmpty, push, pop;

    assign fifoFull = (count_reg == DEPTH_CNT);
    assign fifoEmpty = (count_reg == '0);
    assign push = regReq.write && (regReq.addr == TONE_BUS_FIFO_DATA_OFS)
                  && !fifoFull; // R11
    assign pop = txValid && txReady;
    assign txValid = !fifoEmpty;
    assign txData = mem_reg[rdPtr_reg];

    always_comb begin
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (push) begin // R7
            wrPtr_next = (wrPtr_reg == LAST_IDX) ? '0 : wrPtr_reg + 1'b1;
        end
        if (pop) begin
            rdPtr_next = (rdPtr_reg == LAST_IDX) ? '0 : rdPtr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wrPtr_reg] <= regReq.wdata; // R7
        end
    end

    // ******************************************************************
    // Status and lock pin
    // ******************************************************************
    always_comb begin
        status = 8'h00;
        status[STATUS_INPUT_PIN_BIT] = generalInputPin; // R4
        status[STATUS_REPEATER_BIT] = repeaterDataLine; // R5
        status[STATUS_EMPTY_BIT] = fifoEmpty; // R6
        status[STATUS_FULL_BIT] = fifoFull; // R6
    end

    always_comb begin
        unique case (ctrl_reg.lockSel) // R1
            LOCK_SEL_LOW: lockLevel = 1'b0;
            LOCK_SEL_HIGH: lockLevel = 1'b1;
            LOCK_SEL_CARRIER: lockLevel = carrierFound;
            LOCK_SEL_LOCKED: lockLevel = demodLocked;
        endcase
    end

    // ******************************************************************
    // Register writes
    // ******************************************************************
    always_comb begin
        convLow_next = convLow_reg;
        ctrl_next = ctrl_reg;
        fifoData_next = fifoData_reg;
        if (regReq.write) begin
            unique case (regReq.addr)
                CONVERTER_VALUE_LOW_OFS: convLow_next = regReq.wdata; // R8
                TONE_BUS_LOCK_CONTROL_OFS: ctrl_next = regReq.wdata;
                TONE_BUS_FIFO_DATA_OFS: begin
                    if (!fifoFull) begin
                        fifoData_next = regReq.wdata; // R11
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            convLow_reg <= CONVERTER_VALUE_LOW_RST; // R8
            ctrl_reg <= TONE_BUS_LOCK_CONTROL_RST;
            fifoData_reg <= TONE_BUS_FIFO_DATA_RST; // R7
        end else begin
            convLow_reg <= convLow_next;
            ctrl_reg <= ctrl_next;
            fifoData_reg <= fifoData_next;
        end
    end

    // ******************************************************************
    // Read data
    // ******************************************************************
    always_comb begin
        rdata_next = rdata_reg;
        if (regReq.read) begin
            unique case (regReq.addr)
                CONVERTER_VALUE_LOW_OFS: rdata_next = convLow_reg;
                TONE_BUS_LOCK_CONTROL_OFS: rdata_next = ctrl_reg;
                TONE_BUS_FIFO_DATA_OFS: rdata_next = fifoData_reg;
                TONE_BUS_STATUS_OFS: rdata_next = status;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ******************************************************************
    // Converter value
    // ******************************************************************
    always_comb begin
        conv_next = {converterHighNibble, convLow_reg}; // R10
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            conv_reg <= '0;
        end else begin
            conv_reg <= conv_next;
        end
    end

    // ******************************************************************
    // Lock pin driver
    // ******************************************************************
    always_comb begin
        if (ctrl_reg.lockOpenDrain) begin // R2
            lockOut_next = 1'b0;
            lockOe_next = !lockLevel;
        end else begin
            lockOut_next = lockLevel;
            lockOe_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lockOut_reg <= 1'b0;
            lockOe_reg <= 1'b0;
        end else begin
            lockOut_reg <= lockOut_next;
            lockOe_reg <= lockOe_next;
        end
    end

    assign regRData = rdata_reg;
    assign converterValue = conv_reg;
    assign lockPinOut = lockOut_reg;
    assign lockPinOe = lockOe_reg;
    assign burstSel = ctrl_reg.burstSel; // R9
    assign toneMode = ctrl_reg.toneMode;

endmodule

// ---- testbench/tone_bus_lock_asserts.sv ----
// Checker tying slice outputs to register writes and pin inputs.
`timescale 1ns/1ps
module tone_bus_lock_asserts
    import tone_bus_lock_pkg::*;
#(parameter int FIFO_DEPTH = 8) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire reg_req_t regReq,
    input wire logic [7:0] regRData,
    input wire logic [3:0] converterHighNibble,
    input wire logic [CONVERTER_WIDTH-1:0] converterValue,
    input wire logic carrierFound,
    input wire logic demodLocked,
    input wire logic lockPinOut,
    input wire logic lockPinOe,
    input wire logic generalInputPin,
    input wire logic repeaterDataLine,
    input wire logic burstSel,
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txReady
);
    logic [7:0] ctrlSh, lowSh, a;
    logic lvl, pushSh, popSh, fullSh;
    int cntSh;
    assign a = regReq.addr;
    assign lvl = ctrlSh[7] ? (ctrlSh[6] ? demodLocked : carrierFound)
        : ctrlSh[6];
    assign fullSh = (cntSh == FIFO_DEPTH);
    assign pushSh = regReq.write && a == TONE_BUS_FIFO_DATA_OFS && !fullSh;
    assign popSh = txValid && txReady;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrlSh <= TONE_BUS_LOCK_CONTROL_RST;
            lowSh <= CONVERTER_VALUE_LOW_RST;
            cntSh <= 0;
        end else begin
            if (regReq.write && a == TONE_BUS_LOCK_CONTROL_OFS) begin
                ctrlSh <= regReq.wdata;
            end
            if (regReq.write && a == CONVERTER_VALUE_LOW_OFS) begin
                lowSh <= regReq.wdata;
            end
            cntSh <= cntSh + int'(pushSh) - int'(popSh);
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_lock_push: assert property (!$past(ctrlSh[5]) |->
        lockPinOe && lockPinOut == $past(lvl)) else $error("lock push bad");
    a_lock_drain: assert property ($past(ctrlSh[5]) |->
        !lockPinOut && lockPinOe == !$past(lvl)) else $error("lock drain bad");
    a_burst_sel: assert property (burstSel == ctrlSh[2])
        else $error("burst select bad");
    a_conv_value: assert property (converterValue ==
        {$past(converterHighNibble), $past(lowSh)}) else $error("conv bad");
    a_status_read: assert property (regReq.read && a == 8'h0a |=>
        regRData == {$past(generalInputPin), $past(repeaterDataLine), 4'h0,
        !$past(txValid), $past(fullSh)}) else $error("status bad");
    a_fifo_valid: assert property (txValid == (cntSh != 0))
        else $error("fifo valid bad");
    a_ctrl_read: assert property (regReq.read && a == 8'h08 |=>
        regRData == $past(ctrlSh)) else $error("control read bad");
    a_push_first: assert property (regReq.write && a == 8'h09 && !txValid
        |=> txValid && txData == $past(regReq.wdata)) else $error("push bad");
    a_hold_head: assert property (txValid && !txReady |=>
        txValid && $stable(txData)) else $error("head not held");
    c_pop: cover property (txValid && txReady);
    c_busy_push: cover property (regReq.write && a == 8'h09 && txValid);
    c_status: cover property (regReq.read && a == 8'h0a);
    c_full_push: cover property (regReq.write && a == 8'h09 && fullSh);
endmodule
bind tone_bus_lock_status_regs tone_bus_lock_asserts #(
    .FIFO_DEPTH(FIFO_DEPTH)
) chk (
    .core_clk(core_clk),
    .rstn(rstn),
    .regReq(regReq),
    .regRData(regRData),
    .converterHighNibble(converterHighNibble),
    .converterValue(converterValue),
    .carrierFound(carrierFound),
    .demodLocked(demodLocked),
    .lockPinOut(lockPinOut),
    .lockPinOe(lockPinOe),
    .generalInputPin(generalInputPin),
    .repeaterDataLine(repeaterDataLine),
    .burstSel(burstSel),
    .txValid(txValid),
    .txData(txData),
    .txReady(txReady)
);

// ---- testbench/tone_line_drain.sv ----
// Dish-side consumer that drains the tone bus transmit queue.
`timescale 1ns/1ps
module tone_line_drain (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic stall,
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady
);
    logic [7:0] got[$];
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txReady <= 1'b0;
            got.delete();
        end else begin
            if (txValid && txReady) got.push_back(txData);
            txReady <= !stall;
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
// Testbench for the tone bus, lock pin and status register slice.
`timescale 1ns/1ps
module tb_top;
    import tone_bus_lock_pkg::*;
    logic core_clk, rstn, stall, txValid, txReady, lockPinOut, lockPinOe;
    logic carrierFound, demodLocked, generalInputPin, repeaterDataLine;
    logic burstSel, lvl;
    logic [1:0] toneMode;
    logic [3:0] converterHighNibble;
    logic [7:0] regRData, txData, rd;
    logic [11:0] converterValue;
    reg_req_t regReq;
    int failures = 0, checks = 0, cycles = 0;
    tone_bus_lock_status_regs #(
        .FIFO_DEPTH(2)
    ) dut (
        .core_clk(core_clk),
        .rstn(rstn),
        .regReq(regReq),
        .regRData(regRData),
        .converterHighNibble(converterHighNibble),
        .converterValue(converterValue),
        .carrierFound(carrierFound),
        .demodLocked(demodLocked),
        .lockPinOut(lockPinOut),
        .lockPinOe(lockPinOe),
        .generalInputPin(generalInputPin),
        .repeaterDataLine(repeaterDataLine),
        .burstSel(burstSel),
        .toneMode(toneMode),
        .txValid(txValid),
        .txData(txData),
        .txReady(txReady)
    );
    tone_line_drain partner (
        .core_clk(core_clk),
        .rstn(rstn),
        .stall(stall),
        .txValid(txValid),
        .txData(txData),
        .txReady(txReady)
    );
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [11:0] e, g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        regReq <= '{a, 1'b1, 1'b0, d};
        @(posedge core_clk);
        regReq <= '0;
    endtask
    task automatic rdreg(input logic [7:0] a);
        @(posedge core_clk);
        regReq <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge core_clk);
        regReq <= '0;
        #1 rd = regRData;
    endtask
    task automatic t_reset();
        chk("lock pin", 12'h0, {lockPinOut, lockPinOe});
        rdreg(8'h07);
        chk("low byte", 12'h00, rd);
        rdreg(8'h08);
        chk("control", 12'h60, rd);
        rdreg(8'h09);
        chk("fifo reg", 12'h00, rd);
        rdreg(8'h0a);
        chk("status", 12'h82, rd);
        rdreg(8'h0b);
        chk("reserved", 12'h00, rd);
        $display("test reset done");
    endtask
    task automatic t_lock();
        logic [1:0] pinExp;
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            carrierFound <= !i[3];
            demodLocked <= i[3];
            wr(8'h08, {i[2:0], 2'b00, i[0], i[1:0]});
            @(posedge core_clk);
            #1 lvl = i[2] ? (i[1] ? i[3] : !i[3]) : i[1];
            pinExp = i[0] ? {1'b0, !lvl} : {lvl, 1'b1};
            chk("lock pin", pinExp, {lockPinOut, lockPinOe});
            chk("mode", {i[0], i[1:0]}, {burstSel, toneMode});
        end
        rdreg(8'h08);
        chk("control", 12'he7, rd);
        $display("test lock done");
    endtask
    task automatic t_conv();
        @(posedge core_clk);
        converterHighNibble <= 4'ha;
        wr(8'h07, 8'h5c);
        @(posedge core_clk);
        #1 chk("converter", 12'ha5c, converterValue);
        rdreg(8'h07);
        chk("low byte", 12'h5c, rd);
        $display("test converter done");
    endtask
    task automatic t_fifo();
        @(posedge core_clk);
        stall <= 1'b1;
        generalInputPin <= 1'b0;
        repeaterDataLine <= 1'b1;
        wr(8'h09, 8'h11);
        wr(8'h09, 8'h22);
        rdreg(8'h0a);
        chk("status", 12'h41, rd);
        chk("valid", 12'h1, txValid);
        chk("head", 12'h11, txData);
        wr(8'h09, 8'h33);
        rdreg(8'h09);
        chk("fifo reg", 12'h22, rd);
        stall <= 1'b0;
        for (int n = 0; n < 20 && txValid; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk("valid", 12'h0, txValid);
        chk("count", 12'h2, 12'(partner.got.size()));
        chk("first", 12'h11, partner.got[0]);
        chk("second", 12'h22, partner.got[1]);
        rdreg(8'h0a);
        chk("status", 12'h42, rd);
        $display("test fifo done");
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        stall = 1'b0;
        regReq = '0;
        converterHighNibble = 4'h0;
        carrierFound = 1'b1;
        demodLocked = 1'b0;
        generalInputPin = 1'b1;
        repeaterDataLine = 1'b0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1 t_reset();
        t_lock();
        t_conv();
        t_fifo();
        end_of_test();
    end
endmodule
